// *** shared/cxpu_pkg.sv ***
package cxpu_pkg;
    // ****************************************
    // status word fields
    // ****************************************
    localparam int          SR_W          = 16;
    localparam int          SR_SUPER_BIT  = 13;
    localparam int          SR_TRACE_BIT  = 15;
    localparam int          SR_MASK_LO    = 8;
    localparam logic [15:0] SR_RESET_VAL  = 16'h2700;
    localparam logic [2:0]  LEVEL_MAX     = 3'h7;
    localparam logic [2:0]  LEVEL_NONE    = 3'h0;

    // ****************************************
    // reference class codes
    // ****************************************
    localparam logic [2:0] RC_USER_DATA  = 3'h1;
    localparam logic [2:0] RC_USER_PROG  = 3'h2;
    localparam logic [2:0] RC_SUPER_DATA = 3'h5;
    localparam logic [2:0] RC_SUPER_PROG = 3'h6;
    localparam logic [2:0] RC_INT_ACK    = 3'h7;

    // ****************************************
    // vector numbers and address layout
    // ****************************************
    localparam logic [7:0] VEC_RESET     = 8'h00;
    localparam logic [7:0] VEC_BUS_ERR   = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR  = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL   = 8'h04;
    localparam logic [7:0] VEC_ZERO_DIV  = 8'h05;
    localparam logic [7:0] VEC_BOUNDS    = 8'h06;
    localparam logic [7:0] VEC_OVERFLOW  = 8'h07;
    localparam logic [7:0] VEC_PRIV      = 8'h08;
    localparam logic [7:0] VEC_TRACE     = 8'h09;
    localparam logic [7:0] VEC_EMU_A     = 8'h0A;
    localparam logic [7:0] VEC_EMU_F     = 8'h0B;
    localparam logic [7:0] VEC_SPURIOUS  = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
    localparam logic [7:0] VEC_USER_LO   = 8'h40;
    localparam int         ADDR_W        = 24;
    localparam int         VEC_SHIFT     = 2;
    localparam logic [23:0] RESET_PC_ADDR = 24'h00_0004;

    // ****************************************
    // context save and load word counts
    // ****************************************
    localparam logic [2:0] STACK_WORDS_SHORT = 3'h3;
    localparam logic [2:0] STACK_WORDS_LONG  = 3'h7;
    localparam logic [2:0] VEC_WORDS_NORMAL  = 3'h2;
    localparam logic [2:0] VEC_WORDS_RESET   = 3'h4;
    localparam int         ABORT_LIMIT_CYC   = 2;

    // ****************************************
    // exception kinds and sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        EK_NONE, EK_RESET, EK_ADDR_ERR, EK_BUS_ERR, EK_TRACE, EK_INTR,
        EK_ILLEGAL, EK_PRIV, EK_EMU_A, EK_EMU_F, EK_TRAP, EK_OVERFLOW,
        EK_BOUNDS, EK_ZERO_DIV
    } cxpu_kind_t;

    typedef enum logic [5:0] {
        ST_RUN     = 6'b000001,
        ST_STATUS  = 6'b000010,
        ST_VECTOR  = 6'b000100,
        ST_IACK    = 6'b001000,
        ST_STACK   = 6'b010000,
        ST_FETCH   = 6'b100000
    } cxpu_state_t;
endpackage

// *** hdl/cxpu_exception_unit.sv ***
`timescale 1ns/1ps
//
// Contract
// - user-state instruction cycles tagged user class
// - user state selects user stack pointer
// - user to supervisor only through exceptions
// - supervisor to user only via status writes
// - fixed reference class codes, three unused
// - four ordered exception phases
// - phase one copies status, sets supervisor
// - interrupts read vector via acknowledge cycle
// - vector address is number times four
// - vectors two words, reset four words
// - autovector number is 24 plus level
// - vectors 64 to 255 are user
// - push pc and status, bus errors more
// - load pc from vector then fetch
// - abort group starts within two cycles
// - post-instruction group taken before next instruction
// - instruction group raised by its instruction
// - priority by group then within group
// - bus error abandons software trap
// - trace first, then pending interrupt
// - supervisor flag high means supervisor state
// - exception cycles supervisor, supervisor stack
// - request lines active low, zero none
module cxpu_exception_unit
    import cxpu_pkg::*;
(
    // clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESET_N,
    // instruction side events
    input  wire logic                  INSTR_END,
    input  wire logic                  NEXT_ILLEGAL,
    input  wire logic                  NEXT_PRIV,
    input  wire logic                  NEXT_EMU_A,
    input  wire logic                  NEXT_EMU_F,
    input  wire logic                  TRAP_REQ,
    input  wire logic [3:0]            TRAP_NUM,
    input  wire logic                  OVERFLOW_TRAP,
    input  wire logic                  BOUNDS_TRAP,
    input  wire logic                  ZERO_DIV_TRAP,
    input  wire logic                  BUS_ERROR,
    input  wire logic                  ADDR_ERROR,
    // status word writes by instructions
    input  wire logic                  SR_WRITE,
    input  wire logic [15:0]           SR_WDATA,
    input  wire logic                  SR_WRITE_OK,
    // bus cycle reporting
    input  wire logic                  CYCLE_PROGRAM,
    input  wire logic                  CYCLE_DONE,
    // interrupt pins and acknowledge answer
    input  wire logic [2:0]            INTERRUPT_REQUEST_LINES_N,
    input  wire logic                  IACK_DONE,
    input  wire logic                  IACK_AUTO,
    input  wire logic                  IACK_BUS_ERR,
    input  wire logic [15:0]           DATA_IN,
    // status and classification
    output logic [15:0]                STATUS_WORD,
    output logic                       SUPERVISOR,
    output logic                       USE_USER_SP,
    output logic [2:0]                 REFERENCE_CLASS,
    // exception sequencing
    output logic                       EXC_ACTIVE,
    output logic                       ABORT_INSTR,
    output logic                       IACK_REQ,
    output logic [2:0]                 IACK_LEVEL,
    output logic [7:0]                 VECTOR_NUM,
    output logic [23:0]                VECTOR_ADDR,
    output logic [2:0]                 VECTOR_WORDS,
    output logic                       STACK_REQ,
    output logic [2:0]                 STACK_WORDS,
    output logic [15:0]                STACKED_SR,
    output logic                       FETCH_REQ,
    output logic                       RESET_SP_LOAD,
    output logic                       RESUME
);
    import cxpu_pkg::*;

    // ****************************************
    // state
    // ****************************************
    cxpu_state_t state_q;
    cxpu_kind_t  kind_q;
    logic [15:0] sr_q;
    logic [15:0] sr_copy_q;
    logic [7:0]  vec_q;
    logic [2:0]  ilevel_q;
    logic [2:0]  prev_level_q;
    logic        nmi_q;
    logic        rst_pend_q;
    logic        trace_armed_q;
    logic [3:0]  trap_num_q;
    logic        aborting_q;
    logic        iack_q;
    logic        stack_q;
    logic        fetch_q;
    logic        resume_q;
    logic        rsp_q;
    logic [2:0]  class_q;

    // ****************************************
    // request decode
    // ****************************************
    logic [2:0]  req_level;
    logic        int_pending;
    logic        super_flag;
    logic        post_any;
    logic        chain;
    cxpu_kind_t  pick;

    assign req_level   = ~INTERRUPT_REQUEST_LINES_N;
    assign super_flag  = sr_q[SR_SUPER_BIT];
    // level seven bypasses the mask on a rising edge to seven
    assign int_pending = (req_level != LEVEL_NONE) &&
                         ((req_level > sr_q[SR_MASK_LO +: 3]) || nmi_q);
    // any post-instruction exception outranks the instruction-caused group
    assign post_any    = trace_armed_q || int_pending || NEXT_ILLEGAL || NEXT_PRIV || NEXT_EMU_A || NEXT_EMU_F;
    // trace handled with an interrupt waiting goes straight on to it
    assign chain       = (kind_q == EK_TRACE) && int_pending;

    // priority pick of the next exception
    always_comb begin
        pick = EK_NONE;
        if (ADDR_ERROR) begin
            pick = EK_ADDR_ERR;
        end else if (BUS_ERROR) begin
            pick = EK_BUS_ERR;
        end else if (INSTR_END && post_any) begin
            if (trace_armed_q) begin
                pick = EK_TRACE;
            end else if (int_pending) begin
                pick = EK_INTR;
            end else if (NEXT_ILLEGAL) begin
                pick = EK_ILLEGAL;
            end else if (NEXT_PRIV) begin
                pick = EK_PRIV;
            end else if (NEXT_EMU_A) begin
                pick = EK_EMU_A;
            end else if (NEXT_EMU_F) begin
                pick = EK_EMU_F;
            end
        end else if (TRAP_REQ) begin
            pick = EK_TRAP;
        end else if (OVERFLOW_TRAP) begin
            pick = EK_OVERFLOW;
        end else if (BOUNDS_TRAP) begin
            pick = EK_BOUNDS;
        end else if (ZERO_DIV_TRAP) begin
            pick = EK_ZERO_DIV;
        end
    end

    // vector number for internally numbered exceptions
    function automatic logic [7:0] kind_vec(cxpu_kind_t k, logic [3:0] tn);
        logic [7:0] v;
        v = VEC_RESET;
        unique case (k)
            EK_BUS_ERR:  v = VEC_BUS_ERR;
            EK_ADDR_ERR: v = VEC_ADDR_ERR;
            EK_ILLEGAL:  v = VEC_ILLEGAL;
            EK_ZERO_DIV: v = VEC_ZERO_DIV;
            EK_BOUNDS:   v = VEC_BOUNDS;
            EK_OVERFLOW: v = VEC_OVERFLOW;
            EK_PRIV:     v = VEC_PRIV;
            EK_TRACE:    v = VEC_TRACE;
            EK_EMU_A:    v = VEC_EMU_A;
            EK_EMU_F:    v = VEC_EMU_F;
            EK_TRAP:     v = VEC_TRAP_BASE + {4'h0, tn};
            default:     v = VEC_RESET;
        endcase
        return v;
    endfunction

    // ****************************************
    // interrupt level tracking
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            prev_level_q <= LEVEL_NONE;
            nmi_q        <= 1'b0;
        end else begin
            prev_level_q <= req_level;
            if (req_level == LEVEL_MAX && prev_level_q != LEVEL_MAX) begin
                nmi_q <= 1'b1;
            end else if (state_q == ST_IACK && ilevel_q == LEVEL_MAX) begin
                nmi_q <= 1'b0;
            end else if (req_level != LEVEL_MAX) begin
                nmi_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // exception sequencer
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_q    <= ST_STATUS;
            kind_q     <= EK_RESET;
            rst_pend_q <= 1'b1;
            vec_q      <= VEC_RESET;
            ilevel_q   <= LEVEL_NONE;
            trap_num_q <= 4'h0;
            aborting_q <= 1'b1;
        end else begin
            rst_pend_q <= 1'b0;
            aborting_q <= 1'b0;
            unique case (state_q)
                ST_RUN: begin
                    if (pick != EK_NONE) begin
                        state_q    <= ST_STATUS;
                        kind_q     <= pick;
                        ilevel_q   <= req_level;
                        trap_num_q <= TRAP_NUM;
                        aborting_q <= (pick == EK_ADDR_ERR) || (pick == EK_BUS_ERR);
                    end
                end
                ST_STATUS: begin
                    vec_q   <= kind_vec(kind_q, trap_num_q);
                    state_q <= (kind_q == EK_INTR) ? ST_IACK : ST_VECTOR;
                end
                ST_IACK: begin
                    if (IACK_DONE) begin
                        if (IACK_BUS_ERR) begin
                            vec_q <= VEC_SPURIOUS;
                        end else if (IACK_AUTO) begin
                            vec_q <= VEC_AUTO_BASE + {5'h00, ilevel_q};
                        end else begin
                            vec_q <= DATA_IN[7:0];
                        end
                        state_q <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    state_q <= (kind_q == EK_RESET) ? ST_FETCH : ST_STACK;
                end
                ST_STACK: begin
                    if (CYCLE_DONE) begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (CYCLE_DONE) begin
                        if (kind_q == EK_TRACE && int_pending) begin
                            state_q  <= ST_STATUS;
                            kind_q   <= EK_INTR;
                            ilevel_q <= req_level;
                        end else begin
                            state_q <= ST_RUN;
                        end
                    end
                end
                default: state_q <= ST_RUN;
            endcase
            if (ADDR_ERROR || BUS_ERROR) begin
                if (state_q == ST_RUN && pick != EK_NONE) begin
                    aborting_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // status word and saved copy
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sr_q          <= SR_RESET_VAL;
            sr_copy_q     <= SR_RESET_VAL;
            trace_armed_q <= 1'b0;
        end else begin
            if (INSTR_END && state_q == ST_RUN) begin
                trace_armed_q <= sr_q[SR_TRACE_BIT];
            end
            if (state_q == ST_STATUS) begin
                sr_copy_q               <= sr_q;
                sr_q[SR_SUPER_BIT]      <= 1'b1;
                sr_q[SR_TRACE_BIT]      <= 1'b0;
                trace_armed_q           <= 1'b0;
                if (kind_q == EK_RESET) begin
                    sr_q[SR_MASK_LO +: 3] <= LEVEL_MAX;
                end else if (kind_q == EK_INTR) begin
                    sr_q[SR_MASK_LO +: 3] <= ilevel_q;
                end
            end else if (state_q == ST_RUN && SR_WRITE) begin
                // only decoded status writes reach here; user state cannot raise S
                if (super_flag && SR_WRITE_OK) begin
                    sr_q <= SR_WDATA;
                end else if (!super_flag) begin
                    sr_q <= {SR_WDATA[15:14], 1'b0, SR_WDATA[12:0]};
                end
            end
        end
    end

    // ****************************************
    // outputs from flops
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            class_q  <= RC_SUPER_PROG;
            iack_q   <= 1'b0;
            stack_q  <= 1'b0;
            fetch_q  <= 1'b0;
            resume_q <= 1'b0;
            rsp_q    <= 1'b0;
        end else begin
            if (state_q == ST_IACK) begin
                class_q <= RC_INT_ACK;
            end else if (state_q != ST_RUN) begin
                class_q <= (kind_q == EK_RESET && state_q == ST_FETCH) ? RC_SUPER_PROG
                                                                       : RC_SUPER_DATA;
            end else if (super_flag) begin
                class_q <= CYCLE_PROGRAM ? RC_SUPER_PROG : RC_SUPER_DATA;
            end else begin
                class_q <= CYCLE_PROGRAM ? RC_USER_PROG : RC_USER_DATA;
            end
            iack_q   <= (state_q == ST_IACK) && !IACK_DONE;
            stack_q  <= (state_q == ST_STACK) && !CYCLE_DONE;
            fetch_q  <= (state_q == ST_FETCH) && !CYCLE_DONE;
            resume_q <= (state_q == ST_FETCH) && CYCLE_DONE && !chain;
            rsp_q    <= (state_q == ST_FETCH) && (kind_q == EK_RESET);
        end
    end

    assign STATUS_WORD     = sr_q;
    assign SUPERVISOR      = sr_q[SR_SUPER_BIT];
    assign USE_USER_SP     = !sr_q[SR_SUPER_BIT] && state_q == ST_RUN;
    assign REFERENCE_CLASS = class_q;
    assign EXC_ACTIVE      = (state_q != ST_RUN);
    assign ABORT_INSTR     = aborting_q;
    assign IACK_REQ        = iack_q;
    assign IACK_LEVEL      = ilevel_q;
    assign VECTOR_NUM      = vec_q;
    // vector number times four inside a 24-bit address, RESET_PC_ADDR in the reset fetch
    assign VECTOR_ADDR     = (kind_q == EK_RESET && state_q == ST_FETCH) ? RESET_PC_ADDR
                             : {14'h0000, vec_q, 2'b00};
    assign VECTOR_WORDS    = (kind_q == EK_RESET) ? VEC_WORDS_RESET : VEC_WORDS_NORMAL;
    assign STACK_REQ       = stack_q;
    assign STACK_WORDS     = (kind_q == EK_BUS_ERR || kind_q == EK_ADDR_ERR) ? STACK_WORDS_LONG
                                                                            : STACK_WORDS_SHORT;
    assign STACKED_SR      = sr_copy_q;
    assign FETCH_REQ       = fetch_q;
    assign RESET_SP_LOAD   = rsp_q;
    assign RESUME          = resume_q;

    // ****************************************
    // checks
    // ****************************************
    user_class_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (state_q == ST_RUN && !super_flag && $past(state_q) == ST_RUN && !$past(super_flag))
        |=> (class_q == RC_USER_DATA || class_q == RC_USER_PROG))
        else $error("user cycle not tagged user");
    class_legal_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        class_q != 3'h0 && class_q != 3'h3 && class_q != 3'h4)
        else $error("unused reference class driven");
    no_user_raise_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (!super_flag && state_q == ST_RUN) |=> !super_flag || $past(pick) != EK_NONE)
        else $error("supervisor entered without exception");
    status_prep_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == ST_STATUS |=> sr_q[SR_SUPER_BIT] && !sr_q[SR_TRACE_BIT] && sr_copy_q == $past(sr_q))
        else $error("status not prepared");
    abort_fast_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (state_q == ST_RUN && BUS_ERROR) |-> ##[1:2] state_q == ST_STATUS)
        else $error("abort exception late");
    autovec_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (state_q == ST_IACK && IACK_DONE && IACK_AUTO && !IACK_BUS_ERR) |=> vec_q == VEC_AUTO_BASE + 8'(ilevel_q))
        else $error("autovector wrong");
    vec_addr_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == ST_STACK |-> VECTOR_ADDR == (ADDR_W'(vec_q) << VEC_SHIFT))
        else $error("vector address wrong");
    reset_nostack_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        kind_q == EK_RESET |-> state_q != ST_STACK)
        else $error("reset stacked context");
    user_sp_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        USE_USER_SP |-> !sr_q[SR_SUPER_BIT])
        else $error("user stack in supervisor");
    cov_intr_c: cover property (@(posedge SYS_CLK) state_q == ST_IACK ##1 state_q == ST_VECTOR);
    cov_trace_int_c: cover property (@(posedge SYS_CLK) kind_q == EK_TRACE ##[1:20] kind_q == EK_INTR);
    cov_buserr_c: cover property (@(posedge SYS_CLK) kind_q == EK_BUS_ERR && state_q == ST_STACK);
endmodule

// *** verification/cxpu_bus_model.sv ***
`timescale 1ns/1ps
module cxpu_bus_model (
    // clock
    input  wire logic        clk,
    // requests from the unit
    input  wire logic        stack_req,
    input  wire logic        fetch_req,
    input  wire logic        iack_req,
    // answer style set by the bench
    input  wire logic [1:0]  mode,
    input  wire logic [7:0]  vec,
    input  wire logic [3:0]  lag,
    // answers
    output logic             cycle_done,
    output logic             iack_done,
    output logic             iack_auto,
    output logic             iack_bus_err,
    output logic [15:0]      data_in
);
    logic [3:0] cnt_q;

    // quiet start, data bus holds a pattern
    initial begin
        cnt_q = 4'h0;
        cycle_done = 1'b0;
        iack_done = 1'b0;
        iack_auto = 1'b0;
        iack_bus_err = 1'b0;
        data_in = 16'h5A5A;
    end

    // answer each request after lag cycles with a one-cycle pulse
    always @(posedge clk) begin
        cycle_done <= 1'b0;
        iack_done <= 1'b0;
        iack_auto <= 1'b0;
        iack_bus_err <= 1'b0;
        data_in <= ~data_in; // released bus never keeps its last value
        if ((stack_req || fetch_req || iack_req) && !cycle_done && !iack_done) begin
            if (cnt_q != lag)
                cnt_q <= cnt_q + 4'h1;
            else begin
                cnt_q <= 4'h0;
                cycle_done <= !iack_req;
                iack_done <= iack_req;
                iack_auto <= iack_req && mode == 2'h1;
                iack_bus_err <= iack_req && mode == 2'h2;
                if (iack_req && mode == 2'h0)
                    data_in <= {8'h00, vec};
            end
        end
    end
endmodule

// *** verification/cpu_exception_privilege_unit_bench.sv ***
`timescale 1ns/1ps
module cpu_exception_privilege_unit_bench;
    import cxpu_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, srw = 1'b0, prog = 1'b0, wok = 1'b1;
    logic        sup, user_stack_pointer, act, abrt, iq, sq, fq, spl, res, cd, idn, iau, ibe;
    logic [15:0] sw, ssr, din, sr_wd = 16'h0000;
    logic [23:0] va;
    logic [10:0] ev = 11'h000;
    logic [7:0]  vn;
    logic [3:0]  lag = 4'h0;
    logic [2:0]  rc, il, vw, swd, irq_n = 3'h7;
    logic [1:0]  pmode = 2'h0;
    logic [3:0]  flags;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    logic [10:0] ev_t [13] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020,
                               11'h0C0, 11'h140, 11'h240, 11'h440, 11'h021, 11'h003, 11'h0E0};
    logic [7:0]  vec_t [13] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h25,
                                8'h04, 8'h08, 8'h0A, 8'h0B, 8'h02, 8'h03, 8'h04};
    logic [7:0]  int_t [3] = '{8'h40, 8'h1D, 8'h18};

    assign flags = {iq, res, fq, sq};
    always #2 clk = ~clk;

    // ****************************************
    // design and far side
    // ****************************************
    cxpu_exception_unit i_cxpu_exception_unit (
        .SYS_CLK(clk), .RESET_N(rst_n), .INSTR_END(ev[6]), .NEXT_ILLEGAL(ev[7]), .NEXT_PRIV(ev[8]),
        .NEXT_EMU_A(ev[9]), .NEXT_EMU_F(ev[10]), .TRAP_REQ(ev[5]), .TRAP_NUM(4'h5), .OVERFLOW_TRAP(ev[4]),
        .BOUNDS_TRAP(ev[3]), .ZERO_DIV_TRAP(ev[2]), .BUS_ERROR(ev[0]), .ADDR_ERROR(ev[1]), .SR_WRITE(srw),
        .SR_WDATA(sr_wd), .SR_WRITE_OK(wok), .CYCLE_PROGRAM(prog), .CYCLE_DONE(cd),
        .INTERRUPT_REQUEST_LINES_N(irq_n), .IACK_DONE(idn), .IACK_AUTO(iau), .IACK_BUS_ERR(ibe),
        .DATA_IN(din), .STATUS_WORD(sw), .SUPERVISOR(sup), .USE_USER_SP(user_stack_pointer), .REFERENCE_CLASS(rc),
        .EXC_ACTIVE(act), .ABORT_INSTR(abrt), .IACK_REQ(iq), .IACK_LEVEL(il), .VECTOR_NUM(vn),
        .VECTOR_ADDR(va), .VECTOR_WORDS(vw), .STACK_REQ(sq), .STACK_WORDS(swd), .STACKED_SR(ssr),
        .FETCH_REQ(fq), .RESET_SP_LOAD(spl), .RESUME(res));
    cxpu_bus_model i_cxpu_bus_model (
        .clk(clk), .stack_req(sq), .fetch_req(fq), .iack_req(iq), .mode(pmode), .vec(int_t[0]),
        .lag(lag), .cycle_done(cd), .iack_done(idn), .iack_auto(iau), .iack_bus_err(ibe), .data_in(din));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // wait for one flag: 0 stack, 1 fetch, 2 resume, 3 acknowledge
    task automatic wait_sig(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (n < 300 && flags[k] !== 1'b1);
        chk(n < 300, 1'b1);
    endtask

    task automatic sr_set(input logic [15:0] v);
        srw <= 1'b1;
        sr_wd <= v;
        @(posedge clk);
        srw <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse(input logic [10:0] bits);
        ev <= bits;
        @(posedge clk);
        ev <= 11'h000;
    endtask

    // stacking then fetch of one exception
    task automatic exc(input logic [7:0] v, input logic [2:0] w, input logic [15:0] old);
        wait_sig(0);
        chk(fq, 1'b0);
        chk(act, 1'b1);
        chk(vn, v);
        chk(va, {14'h0000, v, 2'h0});
        chk(sup, 1'b1);
        chk(sw[15], 1'b0);
        chk(ssr, old);
        chk(rc, RC_SUPER_DATA);
        chk(swd, w);
        chk(vw, VEC_WORDS_NORMAL);
        wait_sig(1);
        chk(sq, 1'b0);
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        chk(sw, SR_RESET_VAL);
        rst_n <= 1'b1;
        wait_sig(1);
        chk(vw, VEC_WORDS_RESET);
        chk(rc, RC_SUPER_PROG);
        chk(spl, 1'b1);
        wait_sig(2);
        chk(act, 1'b0);
        wok <= 1'b0;
        sr_set(16'h0000);
        chk(sup, 1'b1);
        wok <= 1'b1;
        for (int i = 3; i >= 0; i--) begin
            sr_set({2'h0, i[1], 13'h0000});
            prog <= i[0];
            repeat (2) @(posedge clk);
            chk(rc, {i[1], i[0], !i[0]});
            chk(user_stack_pointer, !i[1]);
            chk(sup, i[1]);
        end
        sr_set(16'h2000);
        chk(sup, 1'b0);
        for (int i = 0; i < 13; i++) begin
            sr_set(16'h0000);
            lag <= i[0] ? 4'h3 : 4'h0;
            pulse(ev_t[i]);
            @(posedge clk);
            chk(abrt, ev_t[i][1:0] != 2'h0);
            exc(vec_t[i], (ev_t[i][1:0] != 2'h0) ? STACK_WORDS_LONG : STACK_WORDS_SHORT, 16'h0000);
            wait_sig(2);
        end
        for (int m = 0; m < 3; m++) begin
            sr_set(16'h0000);
            pmode <= m[1:0];
            irq_n <= ~3'h5;
            pulse(11'h040);
            wait_sig(3);
            irq_n <= 3'h7;
            chk(il, 3'h5);
            chk(rc, RC_INT_ACK);
            chk(sw[10:8], 3'h5);
            exc(int_t[m], STACK_WORDS_SHORT, 16'h0000);
            wait_sig(2);
        end
        pmode <= 2'h0;
        sr_set(16'h8000);
        pulse(11'h040);
        @(posedge clk);
        irq_n <= ~3'h3;
        pulse(11'h040);
        exc(VEC_TRACE, STACK_WORDS_SHORT, 16'h8000);
        wait_sig(3);
        irq_n <= 3'h7;
        exc(int_t[0], STACK_WORDS_SHORT, 16'h2000);
        wait_sig(2);
        close_out();
    end
endmodule
